// >>> uod_regs.svh
// Offsets, field positions and reset values of the endpoint descriptor store.
// Assumes byte-wide descriptor fields, one byte per Avalon word (word index = printed offset).
`ifndef UOD_REGS_SVH
`define UOD_REGS_SVH

// Descriptor window, printed offsets used as Avalon word indices
`define UOD_BLK_FIRST 16'hFF30
`define UOD_BLK_LAST 16'hFFAF
`define UOD_OUT0_IDX 7'h78
`define UOD_IN0_IDX 7'h38

// Named registers of out endpoints 7, 6 and 5, and of in endpoint 7
`define UOD_OUT_EP7_CONFIG 16'hFF70
`define UOD_OUT_EP7_XBUF_BASE 16'hFF71
`define UOD_OUT_EP7_BUF_SIZE 16'hFF72
`define UOD_OUT_EP7_XBUF_COUNT 16'hFF73
`define UOD_OUT_EP7_YBUF_BASE 16'hFF75
`define UOD_OUT_EP7_YBUF_COUNT 16'hFF77
`define UOD_OUT_EP6_CONFIG 16'hFF78
`define UOD_OUT_EP6_XBUF_BASE 16'hFF79
`define UOD_OUT_EP6_BUF_SIZE 16'hFF7A
`define UOD_OUT_EP6_XBUF_COUNT 16'hFF7B
`define UOD_OUT_EP6_YBUF_BASE 16'hFF7D
`define UOD_OUT_EP6_YBUF_COUNT 16'hFF7F
`define UOD_OUT_EP5_CONFIG 16'hFF80
`define UOD_IN_EP7_CONFIG 16'hFF30

// Byte offsets inside one eight-byte descriptor
`define UOD_OFS_CFG 3'h0
`define UOD_OFS_XBASE 3'h1
`define UOD_OFS_SIZE 3'h2
`define UOD_OFS_XCNT 3'h3
`define UOD_OFS_RSV0 3'h4
`define UOD_OFS_YBASE 3'h5
`define UOD_OFS_RSV1 3'h6
`define UOD_OFS_YCNT 3'h7

// Configuration byte fields
`define UOD_CFG_EN 7
`define UOD_CFG_ISO 6
`define UOD_CFG_TOGGLE 5
`define UOD_CFG_OVF 5
`define UOD_CFG_DUAL_BUFFER_SELECT 4
`define UOD_CFG_STALL 3
`define UOD_CFG_IE 2
`define UOD_BPS_MSB 4

// Count byte fields
`define UOD_CNT_NACK 7
`define UOD_CNT_MSB 6

// Reset values
`define UOD_BYTE_RST 8'h00
`define UOD_RDATA_RST 32'h0000_0000
`define UOD_RDATA_PAD 24'h00_0000

`endif

// >>> uod_pkg.sv
// Types shared by the endpoint descriptor store and its neighbours.
// Assumes the buffer manager speaks through the request and answer structs below.
`default_nettype none

package uod_pkg;

  typedef enum logic [1:0] {
    UOD_HS_NONE,
    UOD_HS_ACK,
    UOD_HS_NAK,
    UOD_HS_STALL
  } uod_hs_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ep;
    logic [10:0] bytes;
    logic good;
  } uod_req_t;

  typedef struct packed {
    logic done;
    uod_hs_t hs;
    logic stored;
    logic use_y;
    logic iso;
    logic [2:0] ep;
    logic [6:0] count;
    logic [10:0] addr;
    logic [10:0] len;
    logic [7:0] irq;
  } uod_rsp_t;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0] next_y;
    logic waitreq;
    logic [31:0] rdata;
    uod_rsp_t rsp;
  } uod_state_t;

endpackage : uod_pkg

`default_nettype wire

// >>> uod_desc_store.sv
// Endpoint descriptor store: sixteen eight-byte blocks behind an Avalon-MM slave,
// plus the out-transaction bookkeeping of the buffer manager.
// Assumes one 25 MHz clock, synchronous inputs and a master that holds its request.
//
// Behaviour
// [RL1] Eight descriptor bytes per out endpoint
// [RL2] Control endpoint plus seven further out endpoints
// [RL3] Out endpoint 7 occupies FF70h to FF77h
// [RL4] In endpoints same layout, FF68h down FF30h
// [RL5] Successful out sets count byte bit 7
// [RL6] Valid packet pending: non-iso answers NAK
// [RL7] Software clears valid bit to accept more
// [RL8] Isochronous never NAKs, ignores valid bit
// [RL9] Software clears iso valid bit before reading
// [RL10] Count bits 6:0 loaded, bytes for non-iso
// [RL11] Isochronous count holds samples, not bytes
// [RL12] Software reads count for packet size
// [RL13] Base byte gives address bits 10:3
// [RL14] Software programs Y base separately
// [RL15] One size byte, 8-byte units, both buffers
// [RL16] Config bits meaning depends on iso bit
// [RL17] Software sets bit 6 for isochronous
// [RL18] Double-buffer bit 4 clear: X only
// [RL19] Endpoint interrupt only when bit 2 set
// [RL20] Sample size is field value plus one
// [RL21] Double buffer alternates from X, skips full
`timescale 1ns/1ps
`include "uod_regs.svh"
`default_nettype none

module uod_desc_store (
  input wire logic core_clk_in, // 25 MHz system clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic [15:0] avs_address_in, // Word index, equals printed offset
  input wire logic avs_read_in, // Avalon read request
  input wire logic avs_write_in, // Avalon write request
  input wire logic [31:0] avs_writedata_in, // Write data, byte in bits 7:0
  input wire logic [3:0] avs_byteenable_in, // Only lane 0 carries a byte
  output logic [31:0] avs_readdata_out, // Read data, upper bits zero
  output logic avs_waitrequest_out, // Low on the accepting edge
  input wire uod_pkg::uod_req_t ubm_req_in, // Received out packet from the buffer manager
  output uod_pkg::uod_rsp_t ubm_rsp_out // Handshake, buffer choice and commit
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [6:0] out_ep_idx(input logic [2:0] ep);
    out_ep_idx = `UOD_OUT0_IDX - {1'b0, ep, 3'b000};
  endfunction : out_ep_idx

  function automatic logic [6:0] byte_idx(input logic [6:0] blk, input logic [2:0] ofs);
    byte_idx = blk | {4'h0, ofs};
  endfunction : byte_idx

  uod_pkg::uod_state_t s_reg;
  uod_pkg::uod_state_t s_next;

  logic bus_req;
  logic bus_hit;
  logic [6:0] bus_idx;
  logic bus_rsv;
  logic bus_acc;
  logic bus_wr_ok;

  assign bus_req = avs_read_in | avs_write_in;
  assign bus_hit = (avs_address_in >= `UOD_BLK_FIRST) && (avs_address_in <= `UOD_BLK_LAST);
  assign bus_idx = 7'(avs_address_in - `UOD_BLK_FIRST);
  // Reserved bytes store nothing and read as zero
  assign bus_rsv = (bus_idx[2:0] == `UOD_OFS_RSV0) || (bus_idx[2:0] == `UOD_OFS_RSV1);
  assign bus_acc = bus_req && !s_reg.waitreq;
  assign bus_wr_ok = avs_write_in && avs_byteenable_in[0] && bus_hit && !bus_rsv;

  ////////////////////////////////////////////////////////////////////////////
  // Per-request descriptor view of the addressed out endpoint

  logic [6:0] req_blk;
  logic [7:0] req_cfg;
  logic [7:0] req_size;
  logic [7:0] req_xcnt;
  logic [7:0] req_ycnt;
  logic req_iso;
  logic req_dual_buffer_select;
  logic req_pref_y;
  logic req_use_y;
  logic req_full;
  logic [10:0] req_cap;
  logic [10:0] req_samples;
  logic [6:0] req_count;
  logic [7:0] req_xbase;
  logic [7:0] req_ybase;

  assign req_blk = out_ep_idx(ubm_req_in.ep); // RL2
  assign req_cfg = s_reg.mem[req_blk];
  assign req_size = s_reg.mem[byte_idx(req_blk, `UOD_OFS_SIZE)];
  assign req_xcnt = s_reg.mem[byte_idx(req_blk, `UOD_OFS_XCNT)];
  assign req_ycnt = s_reg.mem[byte_idx(req_blk, `UOD_OFS_YCNT)];
  assign req_xbase = s_reg.mem[byte_idx(req_blk, `UOD_OFS_XBASE)];
  assign req_ybase = s_reg.mem[byte_idx(req_blk, `UOD_OFS_YBASE)];
  assign req_iso = req_cfg[`UOD_CFG_ISO]; // RL16
  // Bit 4 is a sample-width bit on isochronous endpoints, so never a mode there
  assign req_dual_buffer_select = !req_iso && req_cfg[`UOD_CFG_DUAL_BUFFER_SELECT]; // RL18
  assign req_pref_y = req_dual_buffer_select && s_reg.next_y[ubm_req_in.ep]; // RL21
  // Skip the preferred buffer while it still holds an unread packet and the other buffer does not
  always_comb begin
    req_use_y = req_pref_y;
    if (req_dual_buffer_select && req_pref_y && req_ycnt[`UOD_CNT_NACK] && !req_xcnt[`UOD_CNT_NACK]) begin
      req_use_y = 1'b0; // RL21
    end else if (req_dual_buffer_select && !req_pref_y && req_xcnt[`UOD_CNT_NACK]
                 && !req_ycnt[`UOD_CNT_NACK]) begin
      req_use_y = 1'b1; // RL21
    end
  end
  assign req_full = req_use_y ? req_ycnt[`UOD_CNT_NACK] : req_xcnt[`UOD_CNT_NACK];
  assign req_cap = {req_size, 3'b000}; // RL15
  // Divider sized for 32-byte samples; 32-byte samples give the smallest count
  assign req_samples = ubm_req_in.bytes
                       / {5'h00, 6'(req_cfg[`UOD_BPS_MSB:0]) + 6'h01}; // RL20
  assign req_count = req_iso ? req_samples[`UOD_CNT_MSB:0]
                             : ubm_req_in.bytes[`UOD_CNT_MSB:0]; // RL10 RL11

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [6:0] cnt_idx;
    logic [6:0] base_idx;
    cnt_idx = '0;
    base_idx = '0;
    s_next = s_reg;
    s_next.rsp.done = 1'b0;
    s_next.rsp.stored = 1'b0;
    s_next.rsp.irq = 8'h00;
    s_next.rsp.hs = uod_pkg::UOD_HS_NONE;

    // Slave: one wait cycle, then the accepting edge
    if (bus_req && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = `UOD_RDATA_RST;
      if (bus_hit && !bus_rsv) begin
        s_next.rdata = {`UOD_RDATA_PAD, s_reg.mem[bus_idx]}; // RL1 RL3 RL4 RL12
      end
    end else if (bus_acc) begin
      s_next.waitreq = 1'b1;
      if (bus_wr_ok) begin
        s_next.mem[bus_idx] = avs_writedata_in[7:0]; // RL7 RL9 RL14 RL17
      end
    end

    // Buffer manager applied last: its valid-bit set outranks a same-cycle clear
    if (ubm_req_in.valid) begin
      s_next.rsp.done = 1'b1;
      s_next.rsp.ep = ubm_req_in.ep;
      s_next.rsp.iso = req_iso;
      s_next.rsp.use_y = req_use_y;
      s_next.rsp.count = req_count;
      s_next.rsp.len = req_cap; // RL15
      base_idx = byte_idx(req_blk, req_use_y ? `UOD_OFS_YBASE : `UOD_OFS_XBASE);
      cnt_idx = byte_idx(req_blk, req_use_y ? `UOD_OFS_YCNT : `UOD_OFS_XCNT);
      s_next.rsp.addr = {s_reg.mem[base_idx], 3'b000}; // RL13
      if (!req_cfg[`UOD_CFG_EN]) begin
        s_next.rsp.hs = uod_pkg::UOD_HS_NONE;
      end else if (!req_iso && req_cfg[`UOD_CFG_STALL]) begin
        s_next.rsp.hs = uod_pkg::UOD_HS_STALL;
      end else if (!req_iso && req_full) begin
        s_next.rsp.hs = uod_pkg::UOD_HS_NAK; // RL6
      end else if (!ubm_req_in.good) begin
        s_next.rsp.hs = uod_pkg::UOD_HS_NONE;
      end else if (ubm_req_in.bytes > req_cap) begin
        // Oversized packet: stall a non-iso endpoint, flag overflow on iso
        if (req_iso) begin
          s_next.mem[req_blk][`UOD_CFG_OVF] = 1'b1;
        end else begin
          s_next.mem[req_blk][`UOD_CFG_STALL] = 1'b1;
          s_next.rsp.hs = uod_pkg::UOD_HS_STALL;
        end
      end else begin
        // Isochronous packets overwrite a pending one and get no handshake
        s_next.rsp.hs = req_iso ? uod_pkg::UOD_HS_NONE : uod_pkg::UOD_HS_ACK; // RL8
        s_next.rsp.stored = 1'b1;
        s_next.mem[cnt_idx] = {1'b1, req_count}; // RL5 RL10
        if (!req_iso) begin
          s_next.mem[req_blk][`UOD_CFG_TOGGLE] = !req_cfg[`UOD_CFG_TOGGLE];
          s_next.rsp.irq[ubm_req_in.ep] = req_cfg[`UOD_CFG_IE]; // RL19
        end
        if (req_dual_buffer_select) begin
          s_next.next_y[ubm_req_in.ep] = !req_use_y; // RL18 RL21
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_out = s_reg.rdata;
  assign avs_waitrequest_out = s_reg.waitreq;
  assign ubm_rsp_out = s_reg.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_wr_store;
    @(posedge core_clk_in) disable iff (srst_in)
      bus_acc && bus_wr_ok && !ubm_req_in.valid
      |=> s_reg.mem[$past(bus_idx)] == $past(avs_writedata_in[7:0]);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("write not stored"); // RL1

  property p_ep7_map;
    @(posedge core_clk_in) disable iff (srst_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == `UOD_OUT_EP7_XBUF_COUNT
      && $past(avs_read_in) && $past(avs_waitrequest_out)
      |-> avs_readdata_out[7:0]
          == $past(s_reg.mem[7'(`UOD_OUT_EP7_XBUF_COUNT - `UOD_BLK_FIRST)]);
  endproperty
  a_ep7_map: assert property (p_ep7_map) else $error("ep7 x count misplaced"); // RL3

  property p_in7_map;
    @(posedge core_clk_in) disable iff (srst_in)
      avs_read_in && !avs_waitrequest_out && avs_address_in == `UOD_IN_EP7_CONFIG
      && $past(avs_read_in) && $past(avs_waitrequest_out)
      |-> avs_readdata_out
          == {`UOD_RDATA_PAD, $past(s_reg.mem[7'(`UOD_IN_EP7_CONFIG - `UOD_BLK_FIRST)])};
  endproperty
  a_in7_map: assert property (p_in7_map) else $error("in ep7 config misplaced"); // RL4

  property p_wait_one;
    @(posedge core_clk_in) disable iff (srst_in)
      bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer timing"); // RL1

  property p_set_valid;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.stored
      |-> s_reg.mem[byte_idx(out_ep_idx(ubm_rsp_out.ep),
                             ubm_rsp_out.use_y ? `UOD_OFS_YCNT : `UOD_OFS_XCNT)]
          == {1'b1, ubm_rsp_out.count};
  endproperty
  a_set_valid: assert property (p_set_valid) else $error("count byte not set"); // RL5

  property p_nak;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_cfg[`UOD_CFG_EN] && !req_iso && !req_cfg[`UOD_CFG_STALL]
      && !req_dual_buffer_select && req_xcnt[`UOD_CNT_NACK]
      |=> ubm_rsp_out.hs == uod_pkg::UOD_HS_NAK && !ubm_rsp_out.stored;
  endproperty
  a_nak: assert property (p_nak) else $error("pending packet not refused"); // RL6

  property p_iso_no_nak;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.done && ubm_rsp_out.iso |-> ubm_rsp_out.hs != uod_pkg::UOD_HS_NAK;
  endproperty
  a_iso_no_nak: assert property (p_iso_no_nak) else $error("isochronous NAK"); // RL8

  property p_byte_count;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.stored && !ubm_rsp_out.iso
      |-> ubm_rsp_out.count == $past(ubm_req_in.bytes[`UOD_CNT_MSB:0]);
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte count wrong"); // RL10

  property p_base_align;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.done |-> ubm_rsp_out.addr[2:0] == 3'h0
                           && ubm_rsp_out.len[2:0] == 3'h0;
  endproperty
  a_base_align: assert property (p_base_align) else $error("buffer not aligned"); // RL13

  property p_len;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid |=> ubm_rsp_out.len == {$past(req_size), 3'b000};
  endproperty
  a_len: assert property (p_len) else $error("buffer length wrong"); // RL15

  property p_single;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && !req_dual_buffer_select |=> !ubm_rsp_out.use_y;
  endproperty
  a_single: assert property (p_single) else $error("Y used in single mode"); // RL18

  property p_irq;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && !req_cfg[`UOD_CFG_IE] |=> ubm_rsp_out.irq == 8'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled"); // RL19

  property p_alternate;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_dual_buffer_select && !req_xcnt[`UOD_CNT_NACK]
      && !req_ycnt[`UOD_CNT_NACK] |=> ubm_rsp_out.use_y == $past(req_pref_y);
  endproperty
  a_alternate: assert property (p_alternate) else $error("buffer order wrong"); // RL21

  property p_xbase;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && !req_use_y |=> ubm_rsp_out.addr == {$past(req_xbase), 3'b000};
  endproperty
  a_xbase: assert property (p_xbase) else $error("X buffer address wrong"); // RL13

  property p_ybase;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_use_y |=> ubm_rsp_out.addr == {$past(req_ybase), 3'b000};
  endproperty
  a_ybase: assert property (p_ybase) else $error("Y buffer address wrong"); // RL13

  property p_skip_x;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_dual_buffer_select && req_pref_y && req_ycnt[`UOD_CNT_NACK]
      && !req_xcnt[`UOD_CNT_NACK] |=> !ubm_rsp_out.use_y;
  endproperty
  a_skip_x: assert property (p_skip_x) else $error("full Y buffer not skipped"); // RL21

  property p_skip_y;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_dual_buffer_select && !req_pref_y && req_xcnt[`UOD_CNT_NACK]
      && !req_ycnt[`UOD_CNT_NACK] |=> ubm_rsp_out.use_y;
  endproperty
  a_skip_y: assert property (p_skip_y) else $error("full X buffer not skipped"); // RL21

  property p_answer;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid |=> ubm_rsp_out.done && ubm_rsp_out.ep == $past(ubm_req_in.ep);
  endproperty
  a_answer: assert property (p_answer) else $error("packet not answered"); // RL2

  property p_rsv_read;
    @(posedge core_clk_in) disable iff (srst_in)
      avs_read_in && !avs_waitrequest_out && bus_hit && bus_rsv
      |-> avs_readdata_out == `UOD_RDATA_RST;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved byte not zero"); // RL1

  property p_unmapped;
    @(posedge core_clk_in) disable iff (srst_in)
      avs_read_in && !avs_waitrequest_out && !bus_hit |-> avs_readdata_out == `UOD_RDATA_RST;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RL2

  property p_iso_x;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_iso |=> !ubm_rsp_out.use_y;
  endproperty
  a_iso_x: assert property (p_iso_x) else $error("isochronous used Y"); // RL16

  property p_wide_sample;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_req_in.valid && req_iso && req_cfg[`UOD_BPS_MSB:0] == 5'h1F
      |=> ubm_rsp_out.count == {1'b0, $past(ubm_req_in.bytes[10:5])};
  endproperty
  a_wide_sample: assert property (p_wide_sample) else $error("sample count wrong"); // RL20

  property p_irq_on;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.stored && !ubm_rsp_out.iso && $past(req_cfg[`UOD_CFG_IE])
      |-> ubm_rsp_out.irq[ubm_rsp_out.ep];
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing"); // RL19

  property p_iso_no_irq;
    @(posedge core_clk_in) disable iff (srst_in)
      ubm_rsp_out.done && ubm_rsp_out.iso |-> ubm_rsp_out.irq == 8'h00;
  endproperty
  a_iso_no_irq: assert property (p_iso_no_irq) else $error("isochronous interrupt"); // RL16

endmodule : uod_desc_store

`default_nettype wire

// >>> uod_ubm_model.sv
// Buffer manager stand-in: offers one received out packet per call.
// Assumes the caller enters send just after a rising edge of core_clk_in.
`timescale 1ns/1ps
`default_nettype none

module uod_ubm_model (
  input wire logic core_clk_in, // System clock
  input wire uod_pkg::uod_rsp_t rsp_in, // Answer from the store
  output uod_pkg::uod_req_t req_out // Packet offer
);
  initial req_out = '0;

  // Fields scrambled after the pulse so a stale value can never pass
  task automatic send(input logic [2:0] ep, input logic [10:0] n, input logic good,
                      output uod_pkg::uod_rsp_t rsp);
    req_out <= '{valid: 1'b1, ep: ep, bytes: n, good: good};
    @(posedge core_clk_in);
    req_out <= '{valid: 1'b0, ep: ~ep, bytes: ~n, good: ~good};
    @(posedge core_clk_in);
    rsp = rsp_in;
  endtask : send
endmodule : uod_ubm_model

`default_nettype wire

// >>> uod_desc_store_test.sv
// Self-checking bench for the endpoint descriptor store.
// Assumes the buffer manager model beside it and the register map header.
`timescale 1ns/1ps
`include "uod_regs.svh"
`default_nettype none

module uod_desc_store_test;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  uod_pkg::uod_req_t req;
  uod_pkg::uod_rsp_t rsp;
  uod_pkg::uod_rsp_t r;
  int miscompares = 0;
  int checked = 0;

  always #20 core_clk = ~core_clk;

  uod_desc_store dut (.core_clk_in(core_clk), .srst_in(srst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .ubm_req_in(req), .ubm_rsp_out(rsp));
  uod_ubm_model ubm (.core_clk_in(core_clk), .rsp_in(rsp), .req_out(req));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge core_clk);
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr8

  task automatic cmp_byte(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    checked++;
    if (q !== {24'h00_0000, e}) begin
      miscompares++;
      $display("wrong value at %0t: byte %h read %h", $time, a, q);
    end
  endtask : cmp_byte

  // Placement fields only judged when a packet was stored
  task automatic cmp_rsp(input uod_pkg::uod_rsp_t g, input uod_pkg::uod_hs_t hs,
    input logic st, input logic uy, input logic [6:0] c, input logic [10:0] ad,
    input logic [10:0] ln, input logic [7:0] irq);
    checked++;
    if ({g.done, g.hs, g.stored, g.irq} !== {1'b1, hs, st, irq} ||
        (st === 1'b1 && {g.use_y, g.count, g.addr, g.len} !== {uy, c, ad, ln})) begin
      miscompares++;
      $display("wrong value at %0t: answer %h", $time, g);
    end
  endtask : cmp_rsp

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    cmp_byte(`UOD_OUT_EP7_CONFIG, 8'h00);
    wr8(`UOD_IN_EP7_CONFIG, 8'hA5);
    wr8(16'hFF68, 8'h5A);
    wr8(16'hFFAF, 8'h3C);
    wr8(16'hFF74, 8'hFF);
    wr8(16'hFFB0, 8'hFF);
    cmp_byte(`UOD_IN_EP7_CONFIG, 8'hA5);
    cmp_byte(16'hFF68, 8'h5A);
    cmp_byte(16'hFFAF, 8'h3C);
    cmp_byte(16'hFF74, 8'h00);
    cmp_byte(16'hFFB0, 8'h00);
  endtask : t_map

  task automatic t_walk;
    wr8(`UOD_OUT_EP7_CONFIG, 8'h84);
    wr8(`UOD_OUT_EP7_XBUF_BASE, 8'h10);
    wr8(`UOD_OUT_EP7_BUF_SIZE, 8'h02);
    ubm.send(3'h7, 11'h00A, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 0, 7'h0A, 11'h080, 11'h010, 8'h80);
    cmp_byte(`UOD_OUT_EP7_XBUF_COUNT, 8'h8A);
    ubm.send(3'h7, 11'h005, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NAK, 0, 0, 7'h00, 11'h000, 11'h000, 8'h00);
    wr8(`UOD_OUT_EP7_XBUF_COUNT, 8'h00);
    ubm.send(3'h7, 11'h005, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 0, 7'h05, 11'h080, 11'h010, 8'h80);
    wr8(`UOD_OUT_EP7_XBUF_COUNT, 8'h00);
    wr8(`UOD_OUT_EP7_CONFIG, 8'h80);
    ubm.send(3'h7, 11'h010, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 0, 7'h10, 11'h080, 11'h010, 8'h00);
    wr8(`UOD_OUT_EP7_XBUF_COUNT, 8'h00);
    ubm.send(3'h7, 11'h011, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_STALL, 0, 0, 7'h00, 11'h000, 11'h000, 8'h00);
    cmp_byte(`UOD_OUT_EP7_CONFIG, 8'hA8);
    wr8(`UOD_OUT_EP7_CONFIG, 8'h80);
    ubm.send(3'h7, 11'h004, 1'b0, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NONE, 0, 0, 7'h00, 11'h000, 11'h000, 8'h00);
    cmp_byte(`UOD_OUT_EP7_XBUF_COUNT, 8'h00);
  endtask : t_walk

  task automatic t_dual_buffer_select;
    wr8(`UOD_OUT_EP6_CONFIG, 8'h90);
    wr8(`UOD_OUT_EP6_XBUF_BASE, 8'h20);
    wr8(`UOD_OUT_EP6_BUF_SIZE, 8'h01);
    wr8(`UOD_OUT_EP6_YBUF_BASE, 8'h30);
    ubm.send(3'h6, 11'h008, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 0, 7'h08, 11'h100, 11'h008, 8'h00);
    ubm.send(3'h6, 11'h003, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 1, 7'h03, 11'h180, 11'h008, 8'h00);
    ubm.send(3'h6, 11'h002, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NAK, 0, 0, 7'h00, 11'h000, 11'h000, 8'h00);
    cmp_byte(`UOD_OUT_EP6_XBUF_COUNT, 8'h88);
    cmp_byte(`UOD_OUT_EP6_YBUF_COUNT, 8'h83);
    wr8(`UOD_OUT_EP6_YBUF_COUNT, 8'h00);
    ubm.send(3'h6, 11'h004, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_ACK, 1, 1, 7'h04, 11'h180, 11'h008, 8'h00);
  endtask : t_dual_buffer_select

  // Two bytes a sample, then 32, valid bit left set on purpose
  task automatic t_iso;
    wr8(`UOD_OUT_EP5_CONFIG, 8'hC1);
    wr8(16'hFF81, 8'h40);
    wr8(16'hFF82, 8'h04);
    ubm.send(3'h5, 11'h00C, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NONE, 1, 0, 7'h06, 11'h200, 11'h020, 8'h00);
    cmp_byte(16'hFF83, 8'h86);
    ubm.send(3'h5, 11'h014, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NONE, 1, 0, 7'h0A, 11'h200, 11'h020, 8'h00);
    cmp_byte(16'hFF83, 8'h8A);
    wr8(16'hFF83, 8'h00);
    wr8(`UOD_OUT_EP5_CONFIG, 8'hDF);
    ubm.send(3'h5, 11'h020, 1'b1, r);
    cmp_rsp(r, uod_pkg::UOD_HS_NONE, 1, 0, 7'h01, 11'h200, 11'h020, 8'h00);
    cmp_byte(16'hFF83, 8'h81);
  endtask : t_iso

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_map();
    t_walk();
    t_dual_buffer_select();
    t_iso();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
endmodule : uod_desc_store_test

`default_nettype wire
